/* design/can_cfg_consts.svh */
// Constants for the phase segment 2, wake filter and CAN pin control block.
// Functional notes
// - The phase segment 2 and wake filter register can be written only while the controller is in configuration mode.
// - With the wake filter select bit set, wake-up activity is detected on the filtered bus line, otherwise on the raw line.
// - The three-bit phase segment 2 field gives a segment length of the field value plus one time quantum, 1 TQ to 8 TQ.
// - The programmed phase segment 2 field is ignored whenever the free-programming select bit of the second timing register is clear.
// - With the drive-high enable set the transmit pin is driven high during recessive bits, otherwise it floats then.
// - Unimplemented bits of both registers read as zero and ignore writes.
`ifndef CAN_CFG_CONSTS_SVH
`define CAN_CFG_CONSTS_SVH

// Register offsets on the plain register port.
`define PHASE2_WAKE_TIMING_OFS 8'h00
`define CAN_PIN_CONTROL_OFS    8'h01

// Field positions of the phase segment 2 and wake filter register.
`define WAKE_FILT_BIT          6
`define PS2_LEN_MSB            2
`define PS2_LEN_LSB            0

// Field positions of the CAN pin control register.
`define DRIVE_HIGH_BIT         5
`define CAPTURE_ROUTE_BIT      4

// Reset values of the two registers.
`define PHASE2_WAKE_RESET      8'h00
`define CAN_PIN_CONTROL_RESET  8'h00

// Line filter: consecutive cycles a new level must hold, and the idle level.
`define LINE_FILTER_CYCLES     4
`define LINE_IDLE_LEVEL        1'b1

`endif

/* design/can_cfg_pkg.sv */
// Types shared by the phase segment 2, wake filter and pin control block.
package can_cfg_pkg;

    // Whole state of the register and pin logic.
    typedef struct packed {
        logic [2:0] ps2_len;
        logic       wake_filt_sel;
        logic       drive_high_en;
        logic       capture_en;
        logic [7:0] rdata;
        logic [3:0] ps2_tq;
        logic       tx_pin;
        logic       tx_oe_n;
        logic       capture_in;
        logic       wake_prev;
        logic       wake_pulse;
    } cfg_state_t;

    // Whole state of the bus line filter.
    typedef struct packed {
        logic [7:0] cnt;
        logic       level;
    } filt_state_t;

endpackage : can_cfg_pkg

/* design/line_filter_if.sv */
// Interface joining the raw bus line to its line filter.
`timescale 1ns/1ps
interface line_filter_if;
    logic raw;
    logic filtered;

    modport src (output raw, input filtered);
    modport flt (input raw, output filtered);
endinterface : line_filter_if

/* design/can_line_filter.sv */
// Bus line filter that suppresses short glitches on the received line.
`timescale 1ns/1ps
`include "can_cfg_consts.svh"
module can_line_filter #(
    parameter int unsigned FILTER_CYCLES = `LINE_FILTER_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    line_filter_if.flt       line
);

    can_cfg_pkg::filt_state_t state_q;
    can_cfg_pkg::filt_state_t state_d;

    // A new level is taken only after it held for FILTER_CYCLES cycles in a row,
    // so any pulse shorter than that never reaches the filtered line.
    always_comb
    begin
        state_d = state_q;
        if (line.raw == state_q.level)
        begin
            state_d.cnt = 8'h00;
        end
        else if (state_q.cnt == 8'(FILTER_CYCLES - 1))
        begin
            state_d.level = line.raw;
            state_d.cnt   = 8'h00;
        end
        else
        begin
            state_d.cnt = state_q.cnt + 8'h01;
        end
    end

    // Synchronous reset to the idle (recessive) level.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_q.cnt   <= 8'h00;
            state_q.level <= `LINE_IDLE_LEVEL;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign line.filtered = state_q.level;

endmodule : can_line_filter

/* design/can_phase2_wake_io_config.sv */
// Phase segment 2 and wake filter timing register with CAN pin control.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "can_cfg_consts.svh"
module can_phase2_wake_io_config #(
    parameter int unsigned FILTER_CYCLES = `LINE_FILTER_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       config_mode,
    input  wire logic       phase_seg2_free_prog_sel,
    input  wire logic [3:0] auto_phase_seg2_tq,
    output logic      [3:0] phase_seg2_tq,
    input  wire logic       can_rx_line,
    output logic            wake_activity,
    input  wire logic       tx_bit,
    output logic            can_transmit_pin_o,
    output logic            can_transmit_pin_oe_n,
    input  wire logic       can_rx_msg,
    input  wire logic       capture_input_pin,
    output logic            capture_unit_in
);

    can_cfg_pkg::cfg_state_t state_q;
    can_cfg_pkg::cfg_state_t state_d;
    logic                    wake_src;
    line_filter_if           filt_bus ();

    // Read image of the timing register; unimplemented bits stay zero.
    function automatic logic [7:0] timing_image(input logic [2:0] len, input logic filt);
        logic [7:0] img;
        img                                 = 8'h00;
        img[`PS2_LEN_MSB:`PS2_LEN_LSB]      = len;
        img[`WAKE_FILT_BIT]                 = filt;
        return img;
    endfunction : timing_image

    // Read image of the pin control register; unimplemented bits stay zero.
    function automatic logic [7:0] pin_image(input logic drv, input logic cap);
        logic [7:0] img;
        img                     = 8'h00;
        img[`DRIVE_HIGH_BIT]    = drv;
        img[`CAPTURE_ROUTE_BIT] = cap;
        return img;
    endfunction : pin_image

    // Segment length in time quanta is the field plus one.
    function automatic logic [3:0] seg2_tq(input logic [2:0] len);
        return {1'b0, len} + 4'h1;
    endfunction : seg2_tq

    // The raw line goes through the filter; both versions stay available.
    // The filter runs even while unselected, so a switch-over sees a settled level.
    assign filt_bus.raw = can_rx_line;

    can_line_filter #(
        .FILTER_CYCLES (FILTER_CYCLES)
    ) u_line_filter (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .line     (filt_bus.flt)
    );

    // Wake detection uses the filtered line only when selected.
    assign wake_src = state_q.wake_filt_sel ? filt_bus.filtered : can_rx_line;

    // Next state: register writes, read data, and registered pin outputs.
    always_comb
    begin
        state_d            = state_q;
        state_d.rdata      = 8'h00;
        state_d.wake_pulse = 1'b0;

        // Timing register writes are dropped outside configuration mode.
        if (reg_wr && reg_addr == `PHASE2_WAKE_TIMING_OFS && config_mode)
        begin
            state_d.ps2_len       = reg_wdata[`PS2_LEN_MSB:`PS2_LEN_LSB];
            state_d.wake_filt_sel = reg_wdata[`WAKE_FILT_BIT];
        end
        if (reg_wr && reg_addr == `CAN_PIN_CONTROL_OFS)
        begin
            state_d.drive_high_en = reg_wdata[`DRIVE_HIGH_BIT];
            state_d.capture_en    = reg_wdata[`CAPTURE_ROUTE_BIT];
        end

        // Read data stands only in the cycle after the strobe; the timing
        // register reads as zero outside configuration mode, as it is not
        // reachable then, and unmapped offsets read zero.
        if (reg_rd)
        begin
            case (reg_addr)
                `PHASE2_WAKE_TIMING_OFS:
                begin
                    if (config_mode)
                    begin
                        state_d.rdata = timing_image(state_q.ps2_len, state_q.wake_filt_sel);
                    end
                end
                `CAN_PIN_CONTROL_OFS:
                begin
                    state_d.rdata = pin_image(state_q.drive_high_en, state_q.capture_en);
                end
                default:
                begin
                    state_d.rdata = 8'h00;
                end
            endcase
        end

        // The programmed field counts only with free programming selected.
        state_d.ps2_tq = phase_seg2_free_prog_sel ? seg2_tq(state_q.ps2_len)
                                                  : auto_phase_seg2_tq;

        // Dominant drives low; recessive drives high or floats.
        // Floating on recessive lets several nodes share one wired line.
        if (!tx_bit)
        begin
            state_d.tx_pin  = 1'b0;
            state_d.tx_oe_n = 1'b0;
        end
        else
        begin
            state_d.tx_pin  = 1'b1;
            state_d.tx_oe_n = !state_q.drive_high_en;
        end

        // Capture input mux.
        state_d.capture_in = state_q.capture_en ? can_rx_msg : capture_input_pin;

        // A falling edge (start of a dominant level) signals bus activity.
        // The previous level resets to recessive, so a line already dominant when reset ends counts as an edge.
        state_d.wake_prev  = wake_src;
        state_d.wake_pulse = state_q.wake_prev && !wake_src;
    end

    // Synchronous reset clears every register bit and parks the pin floating.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_q.ps2_len       <= 3'h0;
            state_q.wake_filt_sel <= 1'b0;
            state_q.drive_high_en <= 1'b0;
            state_q.capture_en    <= 1'b0;
            state_q.rdata         <= 8'h00;
            state_q.ps2_tq        <= 4'h1;
            state_q.tx_pin        <= 1'b1;
            state_q.tx_oe_n       <= 1'b1;
            state_q.capture_in    <= 1'b0;
            state_q.wake_prev     <= `LINE_IDLE_LEVEL;
            state_q.wake_pulse    <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // All outputs come straight from flip-flops.
    // This keeps combinational glitches away from the transmit pin and its enable.
    assign reg_rdata             = state_q.rdata;
    assign phase_seg2_tq         = state_q.ps2_tq;
    assign wake_activity         = state_q.wake_pulse;
    assign can_transmit_pin_o    = state_q.tx_pin;
    assign can_transmit_pin_oe_n = state_q.tx_oe_n;
    assign capture_unit_in       = state_q.capture_in;

    // Assertions guarding the register and pin behaviour.
    // All of them are off while reset is held, except the two reset checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_cfg_lock;
        reg_wr && reg_addr == `PHASE2_WAKE_TIMING_OFS && !config_mode
            |=> $stable(state_q.ps2_len) && $stable(state_q.wake_filt_sel);
    endproperty
    a_cfg_lock: assert property (p_cfg_lock)
        else $error("Timing register changed outside configuration mode.");

    property p_cfg_write;
        reg_wr && reg_addr == `PHASE2_WAKE_TIMING_OFS && config_mode
            |=> state_q.ps2_len == $past(reg_wdata[2:0])
                && state_q.wake_filt_sel == $past(reg_wdata[6]);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("Timing register write in configuration mode was lost.");

    property p_wake_filtered;
        state_q.wake_filt_sel && $fell(filt_bus.filtered) && $stable(state_q.wake_filt_sel)
            |=> wake_activity;
    endproperty
    a_wake_filtered: assert property (p_wake_filtered)
        else $error("Filtered line edge did not raise wake activity.");

    property p_wake_raw;
        !state_q.wake_filt_sel && $stable(state_q.wake_filt_sel) && $fell(can_rx_line)
            |=> wake_activity;
    endproperty
    a_wake_raw: assert property (p_wake_raw)
        else $error("Raw line edge did not raise wake activity.");

    property p_seg2_len;
        phase_seg2_free_prog_sel |=> phase_seg2_tq == {1'b0, $past(state_q.ps2_len)} + 4'h1;
    endproperty
    a_seg2_len: assert property (p_seg2_len)
        else $error("Phase segment 2 length is not field plus one.");

    property p_seg2_ignored;
        !phase_seg2_free_prog_sel |=> phase_seg2_tq == $past(auto_phase_seg2_tq);
    endproperty
    a_seg2_ignored: assert property (p_seg2_ignored)
        else $error("Programmed phase segment 2 used without free programming.");

    property p_recessive_pin;
        tx_bit |=> can_transmit_pin_o
                   && can_transmit_pin_oe_n == !$past(state_q.drive_high_en);
    endproperty
    a_recessive_pin: assert property (p_recessive_pin)
        else $error("Recessive pin drive does not follow the drive-high enable.");

    property p_dominant_pin;
        !tx_bit |=> !can_transmit_pin_o && !can_transmit_pin_oe_n;
    endproperty
    a_dominant_pin: assert property (p_dominant_pin)
        else $error("Dominant bit not driven low.");

    property p_capture_route;
        1'b1 |=> capture_unit_in == ($past(state_q.capture_en) ? $past(can_rx_msg)
                                                              : $past(capture_input_pin));
    endproperty
    a_capture_route: assert property (p_capture_route)
        else $error("Capture input not routed as selected.");

    property p_unimpl_zero;
        reg_rd |=> ($past(reg_addr) != `PHASE2_WAKE_TIMING_OFS || (reg_rdata & 8'hB8) == 8'h00)
                   && ($past(reg_addr) != `CAN_PIN_CONTROL_OFS || (reg_rdata & 8'hCF) == 8'h00)
                   && ($past(reg_addr) <= `CAN_PIN_CONTROL_OFS || reg_rdata == 8'h00);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("Unimplemented bit read back as one.");

    property p_reset_clear;
        disable iff (1'b0)
        !rst_n |=> state_q.ps2_len == 3'h0 && !state_q.wake_filt_sel
                   && !state_q.drive_high_en && !state_q.capture_en && can_transmit_pin_oe_n;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("Reset left a register bit set.");

    // A read of the timing register outside configuration mode shows nothing.
    property p_locked_read;
        reg_rd && reg_addr == `PHASE2_WAKE_TIMING_OFS && !config_mode
            |=> reg_rdata == 8'h00;
    endproperty
    a_locked_read: assert property (p_locked_read)
        else $error("Timing register readable outside configuration mode.");

    // Pin control takes its two bits in any mode.
    property p_pin_write;
        reg_wr && reg_addr == `CAN_PIN_CONTROL_OFS
            |=> state_q.drive_high_en == $past(reg_wdata[5])
                && state_q.capture_en == $past(reg_wdata[4]);
    endproperty
    a_pin_write: assert property (p_pin_write)
        else $error("Pin control write was lost.");

    // Outputs leave reset floating, unrouted and with a one-quantum segment.
    property p_reset_outputs;
        disable iff (1'b0)
        !rst_n |=> reg_rdata == 8'h00 && phase_seg2_tq == 4'h1 && !wake_activity
                   && can_transmit_pin_o && !capture_unit_in;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("Reset left an output away from its idle value.");

    // With the filter selected, a pulse needs a falling edge of the filtered line,
    // so a glitch that the filter swallows can never wake the controller.
    property p_wake_filt_only;
        wake_activity && $past(state_q.wake_filt_sel) && $past(state_q.wake_filt_sel, 2)
            |-> !$past(filt_bus.filtered) && $past(filt_bus.filtered, 2);
    endproperty
    a_wake_filt_only: assert property (p_wake_filt_only)
        else $error("Wake activity without a filtered line edge.");

    // Without the filter, a pulse needs a falling edge of the raw line.
    property p_wake_raw_only;
        wake_activity && !$past(state_q.wake_filt_sel) && !$past(state_q.wake_filt_sel, 2)
            |-> !$past(can_rx_line) && $past(can_rx_line, 2);
    endproperty
    a_wake_raw_only: assert property (p_wake_raw_only)
        else $error("Wake activity without a raw line edge.");

    // Main scenarios worth seeing in simulation.
    c_cfg_write: cover property (reg_wr && reg_addr == `PHASE2_WAKE_TIMING_OFS && config_mode);
    c_cfg_block: cover property (reg_wr && reg_addr == `PHASE2_WAKE_TIMING_OFS && !config_mode);
    c_wake:      cover property (wake_activity && state_q.wake_filt_sel);
    c_drive_hi:  cover property (tx_bit && state_q.drive_high_en ##1 !can_transmit_pin_oe_n);
    c_capture:   cover property (state_q.capture_en && can_rx_msg != capture_input_pin);

endmodule : can_phase2_wake_io_config

/* test/can_bus_partner.sv */
// Transceiver model: a wired CAN line shared by the transmit pin and one other node.
`timescale 1ns/1ps
module can_bus_partner (
    input  wire logic tx_pin,
    input  wire logic tx_oe_n,
    input  wire logic other_dom,
    output logic      rx_line,
    output logic      rx_msg
);
    // The line is dominant while any node pulls it low; termination holds it recessive.
    // A floating pin never pulls the line, so its stale output value cannot leak through.
    always_comb
    begin
        rx_line = ~((~tx_oe_n & ~tx_pin) | other_dom);
        rx_msg  = rx_line;
    end
endmodule : can_bus_partner

/* test/testbench.sv */
// Self-checking bench for the phase segment 2, wake filter and pin control block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench;
    localparam int unsigned FILT = 2;
    logic       core_clk;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       config_mode;
    logic       free_sel;
    logic [3:0] auto_tq;
    logic [3:0] ps2_tq;
    logic       can_rx_line;
    logic       wake_activity;
    logic       tx_bit;
    logic       tx_pin;
    logic       tx_oe_n;
    logic       can_rx_msg;
    logic       cap_pin;
    logic       cap_in;
    logic       other_dom;
    logic [7:0] q;
    logic [7:0] d;
    logic [3:0] a;
    logic       dh;
    logic       cap;
    int         errors;
    int         checks;
    int         wakes = 0;
    int         base;
    int         i;

    can_phase2_wake_io_config #(.FILTER_CYCLES(FILT)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_mode(config_mode),
        .phase_seg2_free_prog_sel(free_sel), .auto_phase_seg2_tq(auto_tq),
        .phase_seg2_tq(ps2_tq), .can_rx_line(can_rx_line), .wake_activity(wake_activity),
        .tx_bit(tx_bit), .can_transmit_pin_o(tx_pin), .can_transmit_pin_oe_n(tx_oe_n),
        .can_rx_msg(can_rx_msg), .capture_input_pin(cap_pin), .capture_unit_in(cap_in));

    can_bus_partner i_bus (.tx_pin(tx_pin), .tx_oe_n(tx_oe_n), .other_dom(other_dom),
        .rx_line(can_rx_line), .rx_msg(can_rx_msg));

    // Clock and wake pulse counter; a pulse stands one cycle, so one count per pulse.
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (wake_activity === 1'b1)
            wakes++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // Expected read-back of the two registers from the byte written.
    function automatic logic [7:0] timing_exp(input logic [7:0] w);
        return w & 8'h47;
    endfunction : timing_exp

    function automatic logic [7:0] pin_exp(input logic [7:0] w);
        return w & 8'h30;
    endfunction : pin_exp

    // Expected bus line: low while our pin sends dominant or the other node pulls.
    function automatic logic line_exp(input logic bit_in, input logic other);
        return bit_in & ~other;
    endfunction : line_exp

    // One idle cycle follows each write, so no call reassigns a strobe in the same step.
    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        reg_addr  <= ad;
        reg_wdata <= wd;
        reg_wr    <= 1'b1;
        tick(1);
        reg_wr    <= 1'b0;
        tick(1);
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [7:0] ad, output logic [7:0] rv);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        tick(1);
        reg_rd   <= 1'b0;
        #1;
        rv = reg_rdata;
        tick(1);
    endtask : rd

    // Drives a dominant pulse from the other node, then lets the filter settle.
    task automatic glitch(input int w);
        base = wakes;
        other_dom <= 1'b1;
        tick(w);
        other_dom <= 1'b0;
        tick(FILT + 6);
    endtask : glitch

    task automatic final_report;
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (4000) @(posedge core_clk);
        errors++;
        final_report();
    end

    initial
    begin
        core_clk    = 1'b0;
        rst_n       = 1'b0;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        config_mode = 1'b1;
        free_sel    = 1'b0;
        auto_tq     = 4'h1;
        tx_bit      = 1'b1;
        cap_pin     = 1'b0;
        other_dom   = 1'b0;
        errors      = 0;
        checks      = 0;
        void'($urandom(87673));
        // Reset stands for twelve edges; the first write comes on the first edge after.
        tick(11);
        #1;
        `CHK("oe_n in reset", 1'b1, tx_oe_n)
        tick(1);
        rst_n <= 1'b1;
        // Writes outside configuration mode must leave the timing register untouched.
        config_mode <= 1'b0;
        wr(8'h00, 8'h47);
        config_mode <= 1'b1;
        rd(8'h00, q);
        `CHK("timing after locked write", 8'h00, q)
        rd(8'h01, q);
        `CHK("pin control reset", 8'h00, q)
        for (i = 0; i < 8; i++)
        begin
            d = 8'($urandom);
            wr(8'h00, d);
            wr(8'h01, ~d);
            // A write to an unmapped offset must disturb neither register.
            wr(8'($urandom_range(255, 2)), 8'hFF);
            rd(8'h00, q);
            `CHK("timing", timing_exp(d), q)
            rd(8'h01, q);
            `CHK("pin control", pin_exp(~d), q)
            rd(8'($urandom_range(255, 2)), q);
            `CHK("unmapped", 8'h00, q)
        end
        config_mode <= 1'b0;
        rd(8'h00, q);
        `CHK("timing outside config", 8'h00, q)
        config_mode <= 1'b1;
        // Every field code, each followed by the same code ignored through auto mode.
        for (i = 0; i < 8; i++)
        begin
            wr(8'h00, 8'(i) | (8'($urandom) & 8'h40));
            free_sel <= 1'b1;
            a = 4'($urandom_range(8, 1));
            auto_tq <= a;
            tick(2);
            #1;
            `CHK("free phase 2 length", 4'(i + 1), ps2_tq)
            tick(1);
            free_sel <= 1'b0;
            tick(2);
            #1;
            `CHK("auto phase 2 length", a, ps2_tq)
            tick(1);
        end
        // Pin drive and capture routing with random settings and line levels.
        for (i = 0; i < 16; i++)
        begin
            dh = 1'($urandom);
            cap = 1'($urandom);
            wr(8'h01, {2'b00, dh, cap, 4'h0});
            d = 8'($urandom);
            tx_bit <= d[0];
            other_dom <= d[1];
            cap_pin <= d[2];
            tick(3);
            #1;
            `CHK("oe_n", d[0] & ~dh, tx_oe_n)
            if (!(d[0] & ~dh))
                `CHK("tx pin", d[0], tx_pin)
            `CHK("capture in", cap ? line_exp(d[0], d[1]) : d[2], cap_in)
            tick(1);
        end
        tx_bit <= 1'b1;
        other_dom <= 1'b0;
        // Wake detection: a short glitch wakes only the raw path; a long one wakes the filtered path too.
        wr(8'h00, 8'h00);
        tick(6);
        glitch(1);
        `CHK("raw wake on glitch", 1, wakes - base)
        wr(8'h00, 8'h40);
        tick(6);
        glitch(1);
        `CHK("filtered wake on glitch", 0, wakes - base)
        glitch(FILT + 2);
        `CHK("filtered wake on long low", 1, wakes - base)
        base = wakes;
        tx_bit <= 1'b0;
        tick(FILT + 3);
        tx_bit <= 1'b1;
        tick(FILT + 6);
        `CHK("wake from own dominant", 1, wakes - base)
        // A second reset in mid-run clears what was written.
        wr(8'h01, 8'h30);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        rd(8'h00, q);
        `CHK("timing after reset", 8'h00, q)
        rd(8'h01, q);
        `CHK("pin control after reset", 8'h00, q)
        final_report();
    end
endmodule : testbench
